// File: wiorm_top.sv
// gateway register map: per-node input and output words and aliased views
module wiorm_top (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic host_req_valid_i,
	input wire wiorm_pkg::wiorm_req_s host_req_i,
	output logic host_rsp_valid_o,
	output wiorm_pkg::wiorm_rsp_s host_rsp_o,
	input wire logic in_upd_valid_i,
	input wire wiorm_pkg::wiorm_upd_s in_upd_i,
	output logic out_upd_valid_o,
	output wiorm_pkg::wiorm_upd_s out_upd_o,
	input wire logic [5:0] last_node_i,
	input wire logic [47:0] node_sync_i,
	input wire logic pwr_sw_i,
	input wire logic band_24g_i,
	output logic tx_power_low_o,
	output logic legacy_mode_o
);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	// inputs and outputs live apart so radio updates and host writes
	// never contend for one write port
	logic [15:0] in_mem [wiorm_pkg::WORDS];
	logic [15:0] out_mem [wiorm_pkg::WORDS];
	// lsb shadows feed the bit-packed views in a single cycle
	logic [47:0] in_lsb [wiorm_pkg::HALF_REGS];
	logic [47:0] out_lsb [wiorm_pkg::HALF_REGS];

	// ----------------------------------------------------------------
	// pins
	// ----------------------------------------------------------------
	logic [49:0] pin_raw;
	logic [49:0] pin_q;
	logic [47:0] sync_q;
	logic sw_q;
	logic b24_q;

	assign pin_raw = {band_24g_i, pwr_sw_i, node_sync_i};
	assign sync_q = pin_q[47:0];
	assign sw_q = pin_q[48];
	assign b24_q = pin_q[49];

	wiorm_sync #(
		.WIDTH(50)
	) u_sync (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.d_i(pin_raw),
		.q_o(pin_q)
	);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wiorm_pkg::wiorm_dec_s dec;

	wiorm_decode u_dec (
		.regnum_i(host_req_i.regnum),
		.last_node_i(last_node_i),
		.dec_o(dec)
	);

	function automatic logic [8:0] word_idx(input logic [5:0] node,
			input logic [2:0] point);
		word_idx = {node, point};
	endfunction

	// ----------------------------------------------------------------
	// host access
	// ----------------------------------------------------------------
	logic next_rsp_valid;
	wiorm_pkg::wiorm_rsp_s next_rsp;
	logic host_out_we;
	logic [8:0] host_idx;
	logic [8:0] radio_idx;
	logic [47:0] pack_vec;
	logic [3:0] pack_pt;
	logic next_out_upd_valid;
	wiorm_pkg::wiorm_upd_s next_out_upd;

	assign host_idx = word_idx(dec.node, dec.point);
	assign radio_idx = word_idx(in_upd_i.node, in_upd_i.point);

	always_comb begin
		next_rsp_valid = host_req_valid_i;
		next_rsp = '0;
		host_out_we = 1'b0;
		pack_vec = '0;
		pack_pt = '0;
		next_out_upd_valid = 1'b0;
		next_out_upd = '0;
		if (dec.kind == wiorm_pkg::K_DIN) begin
			pack_pt = dec.grp - 4'h1;
		end else if (dec.kind == wiorm_pkg::K_DOUT) begin
			pack_pt = dec.grp - wiorm_pkg::PACK_DOUT_FIRST;
		end
		unique case (dec.kind)
			wiorm_pkg::K_STAT: begin
				pack_vec = sync_q;
			end
			wiorm_pkg::K_DIN: begin
				pack_vec = in_lsb[pack_pt[2:0]];
			end
			wiorm_pkg::K_DOUT: begin
				pack_vec = out_lsb[pack_pt[2:0]];
			end
			default: begin
				pack_vec = '0;
			end
		endcase
		if (host_req_valid_i) begin
			unique case (dec.kind)
				wiorm_pkg::K_IN: begin
					// inputs belong to the radio side
					next_rsp.exc = host_req_i.write;
					next_rsp.data = host_req_i.write ?
						wiorm_pkg::RST_DATA : in_mem[host_idx];
				end
				wiorm_pkg::K_OUT: begin
					if (host_req_i.write) begin
						host_out_we = 1'b1;
						next_out_upd_valid = 1'b1;
						next_out_upd.node = dec.node;
						next_out_upd.point = dec.point;
						next_out_upd.data = host_req_i.data;
					end else begin
						next_rsp.data = out_mem[host_idx];
					end
				end
				wiorm_pkg::K_STAT,
				wiorm_pkg::K_DIN,
				wiorm_pkg::K_DOUT: begin
					// packed views are read-only here
					next_rsp.exc = host_req_i.write;
					if (!host_req_i.write) begin
						next_rsp.data = pack_vec[dec.sub * 16 +: 16];
					end
				end
				wiorm_pkg::K_ANA: begin
					next_rsp.data = wiorm_pkg::RST_DATA;
				end
				default: begin
					next_rsp.exc = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			host_rsp_valid_o <= 1'b0;
			host_rsp_o <= '0;
			out_upd_valid_o <= 1'b0;
			out_upd_o <= '0;
		end else begin
			host_rsp_valid_o <= next_rsp_valid;
			host_rsp_o <= next_rsp;
			out_upd_valid_o <= next_out_upd_valid;
			out_upd_o <= next_out_upd;
		end
	end

	// ----------------------------------------------------------------
	// memories and lsb shadows
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (in_upd_valid_i) begin
			in_mem[radio_idx] <= in_upd_i.data;
		end
		if (host_out_we) begin
			out_mem[host_idx] <= host_req_i.data;
		end
	end

	genvar gp;
	generate
		for (gp = 0; gp < 8; gp++) begin : g_lsb
			always_ff @(posedge mclk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					in_lsb[gp] <= '0;
					out_lsb[gp] <= '0;
				end else begin
					if (in_upd_valid_i && in_upd_i.point == 3'(gp)) begin
						in_lsb[gp][in_upd_i.node] <= in_upd_i.data[0];
					end
					if (host_out_we && dec.point == 3'(gp)) begin
						out_lsb[gp][dec.node] <= host_req_i.data[0];
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// power mode select
	// ----------------------------------------------------------------
	logic next_pwr_low;

	// 2.4 GHz parts have a fixed power, so the switch has no effect there
	assign next_pwr_low = sw_q & ~b24_q;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_power_low_o <= 1'b0;
			legacy_mode_o <= 1'b0;
		end else begin
			tx_power_low_o <= next_pwr_low;
			legacy_mode_o <= next_pwr_low;
		end
	end

endmodule

// File: wiorm_pkg.sv
// constants, types and operation summary for the wireless i/o register map
// Operation
// - gateway keeps its own full 16-register block
// - blocks of 16 registers per device, consecutive
// - register equals point plus sixteen times node
// - block numbering continues for every configured node
// - first eight inputs, last eight outputs
// - aliased regions reorder the same i/o data
// - inputs aliased at 2201-2584, eight per device
// - outputs aliased writable at 4401-4784, eight per device
// - 6601-6753 reserved for bit-packed views
// - 6801-9098 reserved for analog views
// - switch one selects power, ignored on 2.4 GHz
// - status bit is one while node synchronized
package wiorm_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int unsigned NODE_MAX = 48;
	localparam int unsigned NODE_W = 6;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned REG_W = 16;
	localparam int unsigned POINT_W = 3;
	localparam int unsigned HALF_REGS = 8;
	localparam int unsigned WORDS = NODE_MAX * HALF_REGS;
	localparam int unsigned WORD_W = 9;
	localparam int unsigned SYNC_STAGES = 2;

	// ----------------------------------------------------------------
	// register numbers, as seen by the host (first register is 1)
	// ----------------------------------------------------------------
	localparam logic [15:0] PRI_FIRST = 16'h0001;
	localparam logic [15:0] PRI_LAST = 16'h0300;
	localparam logic [15:0] IN_FIRST = 16'h0899;
	localparam logic [15:0] IN_LAST = 16'h0a18;
	localparam logic [15:0] OUT_FIRST = 16'h1131;
	localparam logic [15:0] OUT_LAST = 16'h12b0;
	localparam logic [15:0] PACK_FIRST = 16'h19c9;
	localparam logic [15:0] PACK_LAST = 16'h1a61;
	localparam logic [15:0] ANA_FIRST = 16'h1a91;
	localparam logic [15:0] ANA_LAST = 16'h238a;

	// bit-packed layout: groups of ten numbers, three words used per group
	localparam logic [15:0] PACK_STRIDE = 16'h000a;
	localparam logic [15:0] PACK_WORDS = 16'h0003;
	localparam logic [3:0] PACK_STAT_GRP = 4'h0;
	localparam logic [3:0] PACK_DIN_LAST = 4'h8;
	localparam logic [3:0] PACK_DOUT_FIRST = 4'h9;
	localparam logic [3:0] PACK_DOUT_LAST = 4'hf;

	localparam logic [15:0] RST_DATA = 16'h0000;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		K_NONE = 3'b000,
		K_IN = 3'b001,
		K_OUT = 3'b010,
		K_STAT = 3'b011,
		K_DIN = 3'b100,
		K_DOUT = 3'b101,
		K_ANA = 3'b110
	} wiorm_kind_e;

	typedef struct packed {
		wiorm_kind_e kind;
		logic [5:0] node;
		logic [2:0] point;
		logic [3:0] grp;
		logic [1:0] sub;
	} wiorm_dec_s;

	typedef struct packed {
		logic write;
		logic [15:0] regnum;
		logic [15:0] data;
	} wiorm_req_s;

	typedef struct packed {
		logic exc;
		logic [15:0] data;
	} wiorm_rsp_s;

	typedef struct packed {
		logic [5:0] node;
		logic [2:0] point;
		logic [15:0] data;
	} wiorm_upd_s;

endpackage

// File: wiorm_sync.sv
// two-flop synchroniser for a bundle of pin levels
module wiorm_sync #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta;

	// first stage is read only by the second
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta <= '0;
			q_o <= '0;
		end else begin
			meta <= d_i;
			q_o <= meta;
		end
	end

endmodule

// File: wiorm_decode.sv
// decodes a host register number into view, node and point
module wiorm_decode (
	input wire logic [15:0] regnum_i,
	input wire logic [5:0] last_node_i,
	output wiorm_pkg::wiorm_dec_s dec_o
);

	logic [15:0] off;
	logic [15:0] quo;
	logic [15:0] rem;

	always_comb begin
		dec_o = '0;
		dec_o.kind = wiorm_pkg::K_NONE;
		off = '0;
		quo = '0;
		rem = '0;
		if (regnum_i >= wiorm_pkg::PRI_FIRST &&
				regnum_i <= wiorm_pkg::PRI_LAST) begin
			off = regnum_i - wiorm_pkg::PRI_FIRST;
			dec_o.node = off[9:4];
			dec_o.point = off[2:0];
			dec_o.kind = off[3] ? wiorm_pkg::K_OUT : wiorm_pkg::K_IN;
		end else if (regnum_i >= wiorm_pkg::IN_FIRST &&
				regnum_i <= wiorm_pkg::IN_LAST) begin
			off = regnum_i - wiorm_pkg::IN_FIRST;
			dec_o.node = off[8:3];
			dec_o.point = off[2:0];
			dec_o.kind = wiorm_pkg::K_IN;
		end else if (regnum_i >= wiorm_pkg::OUT_FIRST &&
				regnum_i <= wiorm_pkg::OUT_LAST) begin
			off = regnum_i - wiorm_pkg::OUT_FIRST;
			dec_o.node = off[8:3];
			dec_o.point = off[2:0];
			dec_o.kind = wiorm_pkg::K_OUT;
		end else if (regnum_i >= wiorm_pkg::PACK_FIRST &&
				regnum_i <= wiorm_pkg::PACK_LAST) begin
			off = regnum_i - wiorm_pkg::PACK_FIRST;
			quo = off / wiorm_pkg::PACK_STRIDE;
			rem = off % wiorm_pkg::PACK_STRIDE;
			dec_o.grp = quo[3:0];
			dec_o.sub = rem[1:0];
			// the gaps between groups are unmapped
			if (rem < wiorm_pkg::PACK_WORDS) begin
				if (quo[3:0] == wiorm_pkg::PACK_STAT_GRP) begin
					dec_o.kind = wiorm_pkg::K_STAT;
				end else if (quo[3:0] <= wiorm_pkg::PACK_DIN_LAST) begin
					dec_o.kind = wiorm_pkg::K_DIN;
				end else begin
					dec_o.kind = wiorm_pkg::K_DOUT;
				end
			end
		end else if (regnum_i >= wiorm_pkg::ANA_FIRST &&
				regnum_i <= wiorm_pkg::ANA_LAST) begin
			dec_o.kind = wiorm_pkg::K_ANA;
		end
		if ((dec_o.kind == wiorm_pkg::K_IN ||
				dec_o.kind == wiorm_pkg::K_OUT) &&
				dec_o.node > last_node_i) begin
			dec_o.kind = wiorm_pkg::K_NONE;
		end
	end

endmodule

// File: wiorm_map_properties.sv
// assertions on the host port and power outputs of the register map
module wiorm_map_properties (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic host_req_valid_i,
	input wire wiorm_pkg::wiorm_req_s host_req_i,
	input wire logic host_rsp_valid_o,
	input wire wiorm_pkg::wiorm_rsp_s host_rsp_o,
	input wire logic out_upd_valid_o,
	input wire wiorm_pkg::wiorm_upd_s out_upd_o,
	input wire logic [5:0] last_node_i,
	input wire logic tx_power_low_o,
	input wire logic legacy_mode_o
);
	wire [15:0] r = host_req_i.regnum;
	wire v = host_req_valid_i;
	wire w = v && host_req_i.write;
	wire [15:0] po = r - 16'h0001;
	wire [15:0] ao = r - 16'h1131;
	wire pri = r != 16'h0000 && r <= 16'h0300;
	wire [5:0] pn = po[9:4];
	wire [5:0] an = ao[8:3];
	wire [2:0] pp = po[2:0];
	wire [2:0] ap = ao[2:0];
	wire aout = r >= 16'h1131 && r <= 16'h12b0 && an <= last_node_i;
	wire [15:0] wd = host_req_i.data;
	wire xc = host_rsp_o.exc;

	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	property p_answer;
		v |=> host_rsp_valid_o;
	endproperty
	a_answer: assert property (p_answer)
		else $error("no answer one cycle after request");
	property p_quiet;
		!v |=> !host_rsp_valid_o && !out_upd_valid_o;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("answer or update without request");
	property p_pri_out;
		w && pri && po[3] && pn <= last_node_i |=> out_upd_valid_o
			&& out_upd_o.node == $past(pn) && out_upd_o.point == $past(pp)
			&& out_upd_o.data == $past(wd);
	endproperty
	a_pri_out: assert property (p_pri_out)
		else $error("primary output write misrouted");
	property p_alias_out;
		w && aout |=> out_upd_valid_o && !xc
			&& out_upd_o.node == $past(an) && out_upd_o.point == $past(ap);
	endproperty
	a_alias_out: assert property (p_alias_out)
		else $error("aliased output write misrouted");
	property p_in_ro;
		w && (pri && !po[3] || r >= 16'h0899 && r <= 16'h0a18)
			|=> xc && !out_upd_valid_o;
	endproperty
	a_in_ro: assert property (p_in_ro)
		else $error("input write not refused");
	property p_pack;
		w && r >= 16'h19c9 && r <= 16'h1a61 |=> xc;
	endproperty
	a_pack: assert property (p_pack)
		else $error("packed write not refused");
	property p_ana;
		v && r >= 16'h1a91 && r <= 16'h238a |=> !xc
			&& host_rsp_o.data == 16'h0000;
	endproperty
	a_ana: assert property (p_ana)
		else $error("analog region answer wrong");
	property p_hole;
		v && (r == 16'h0000 || r > 16'h238a || r > 16'h0300 && r < 16'h0899)
			|=> xc && host_rsp_o.data == 16'h0000;
	endproperty
	a_hole: assert property (p_hole)
		else $error("unmapped number not refused");
	property p_node;
		v && pri && pn > last_node_i |=> xc;
	endproperty
	a_node: assert property (p_node)
		else $error("unconfigured node not refused");
	property p_legacy;
		legacy_mode_o == tx_power_low_o;
	endproperty
	a_legacy: assert property (p_legacy)
		else $error("legacy mode differs from low power");
endmodule

bind wiorm_top wiorm_map_properties u_chk (.mclk_i(mclk_i),
	.rst_n_i(rst_n_i), .host_req_valid_i(host_req_valid_i),
	.host_req_i(host_req_i), .host_rsp_valid_o(host_rsp_valid_o),
	.host_rsp_o(host_rsp_o), .out_upd_valid_o(out_upd_valid_o),
	.out_upd_o(out_upd_o), .last_node_i(last_node_i),
	.tx_power_low_o(tx_power_low_o), .legacy_mode_o(legacy_mode_o));

// File: wiorm_host_model.sv
// bus host model issuing one register transfer at a time
module wiorm_host_model (
	input wire logic mclk_i,
	output logic req_valid_o,
	output wiorm_pkg::wiorm_req_s req_o,
	input wire logic rsp_valid_i,
	input wire wiorm_pkg::wiorm_rsp_s rsp_i
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		req_valid_o = 1'b0;
		req_o = '0;
	end
	// all devices are reached through the one gateway station
	task automatic xfer(input logic wr, input logic [15:0] n, d,
			output logic [16:0] got);
		got = 17'h1ffff;
		@(negedge mclk_i);
		req_valid_o = 1'b1;
		req_o = '{wr, n, d};
		// the answer stands for the one cycle after the take edge, so it
		// is picked up mid-cycle before the request is released
		@(negedge mclk_i);
		if (rsp_valid_i === 1'b1) begin
			got = rsp_i;
		end
		req_valid_o = 1'b0;
		// released fields must not keep looking valid
		req_o = ~req_o;
	endtask
endmodule

// File: tb_top.sv
// self-checking bench for the register map
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_i, rst_n_i, rq_v, rs_v, in_v, out_v;
	logic pwr_sw, band, tx_low, legacy;
	logic [5:0] last_node;
	logic [47:0] node_sync;
	logic [16:0] got;
	wiorm_pkg::wiorm_req_s rq;
	wiorm_pkg::wiorm_rsp_s rs;
	wiorm_pkg::wiorm_upd_s in_upd, out_upd;
	int bad_count, checked;

	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	wiorm_top u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.host_req_valid_i(rq_v), .host_req_i(rq),
		.host_rsp_valid_o(rs_v), .host_rsp_o(rs),
		.in_upd_valid_i(in_v), .in_upd_i(in_upd),
		.out_upd_valid_o(out_v), .out_upd_o(out_upd),
		.last_node_i(last_node), .node_sync_i(node_sync),
		.pwr_sw_i(pwr_sw), .band_24g_i(band),
		.tx_power_low_o(tx_low), .legacy_mode_o(legacy));
	wiorm_host_model u_host (.mclk_i(mclk_i), .req_valid_o(rq_v),
		.req_o(rq), .rsp_valid_i(rs_v), .rsp_i(rs));

	task automatic chk(input logic [31:0] a, e);
		checked++;
		if (a !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, a, e);
		end
	endtask
	task automatic rd(input logic [15:0] n, input logic [16:0] e);
		u_host.xfer(1'b0, n, 16'h0000, got);
		chk(got, e);
	endtask
	task automatic radio(input logic [5:0] n, input logic [2:0] p,
			input logic [15:0] d);
		@(negedge mclk_i);
		in_v = 1'b1;
		in_upd = '{n, p, d};
		@(negedge mclk_i);
		in_v = 1'b0;
		in_upd = ~in_upd;
	endtask
	task automatic stop_test();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ----
	// scenarios
	// ----
	task automatic t_outputs();
		u_host.xfer(1'b1, 16'h0019, 16'h5a3c, got);
		chk(got, 32'h0);
		chk({out_v, out_upd}, {1'b1, 6'h01, 3'h0, 16'h5a3c});
		rd(16'h1139, {1'b0, 16'h5a3c});
		u_host.xfer(1'b1, 16'h12b0, 16'hc3a5, got);
		chk({out_v, out_upd}, {1'b1, 6'h2f, 3'h7, 16'hc3a5});
		rd(16'h0300, {1'b0, 16'hc3a5});
		u_host.xfer(1'b1, 16'h0010, 16'h0101, got);
		rd(16'h1138, {1'b0, 16'h0101});
	endtask
	task automatic t_inputs();
		radio(6'h02, 3'h3, 16'h1234);
		rd(16'h0024, {1'b0, 16'h1234});
		rd(16'h08ac, {1'b0, 16'h1234});
		radio(6'h2f, 3'h0, 16'hbeef);
		rd(16'h02f1, {1'b0, 16'hbeef});
		rd(16'h0a11, {1'b0, 16'hbeef});
		u_host.xfer(1'b1, 16'h0024, 16'hffff, got);
		chk({got, out_v}, 32'h20000);
		rd(16'h0024, {1'b0, 16'h1234});
	endtask
	task automatic t_refuse();
		logic [15:0] bad [10] = '{16'h0000, 16'h0301, 16'h0898, 16'h0a19,
			16'h1130, 16'h12b1, 16'h19cc, 16'h1a62, 16'h1a90, 16'h238b};
		foreach (bad[i]) rd(bad[i], 17'h10000);
		u_host.xfer(1'b1, 16'h19c9, 16'h0001, got);
		chk(got, 32'h10000);
		last_node = 6'h03;
		rd(16'h0041, 17'h10000);
		rd(16'h1151, 17'h10000);
		last_node = 6'h2f;
	endtask
	task automatic t_status();
		node_sync = 48'h8000_0001_a5c3;
		repeat (4) @(negedge mclk_i);
		rd(16'h19c9, {1'b0, 16'ha5c3});
		rd(16'h19ca, {1'b0, 16'h0001});
		rd(16'h19cb, {1'b0, 16'h8000});
		// input 1 lsb of node 47 was set by the radio update earlier
		rd(16'h19d5, {1'b0, 16'h8000});
		u_host.xfer(1'b1, 16'h1139, 16'h0001, got);
		chk(got, 32'h0);
		rd(16'h1a23, {1'b0, 16'h0002});
		rd(16'h1a91, 17'h0);
		rd(16'h238a, 17'h0);
	endtask
	task automatic t_power();
		for (int i = 0; i < 4; i++) begin
			@(negedge mclk_i);
			{pwr_sw, band} = i[1:0];
			repeat (4) @(negedge mclk_i);
			chk({tx_low, legacy}, (i == 2) ? 32'h3 : 32'h0);
		end
	endtask

	initial begin
		rst_n_i = 1'b0;
		in_v = 1'b0;
		in_upd = '0;
		last_node = 6'h2f;
		node_sync = '0;
		pwr_sw = 1'b0;
		band = 1'b0;
		bad_count = 0;
		checked = 0;
		repeat (20) @(negedge mclk_i);
		rst_n_i = 1'b1;
		repeat (4) @(negedge mclk_i);
		t_outputs();
		t_inputs();
		t_refuse();
		t_status();
		t_power();
		stop_test();
	end
	// the whole run is about 120 cycles; this is ample margin
	initial begin
		#50us;
		bad_count++;
		stop_test();
	end
endmodule
